// File: hdl/gpio_pin_regs.svh
// register offsets, field positions, codes and reset values
// of the single-pin event and pad control block
// assumes 32-bit apb words at 12-bit byte addresses
`ifndef GPIO_PIN_REGS_SVH
`define GPIO_PIN_REGS_SVH

// byte offsets
`define CFG_OFS 12'h000
`define STAT_OFS 12'h004

// configuration word fields
`define PULL_LSB 0
`define PULL_MSB 1
`define SGATE_LSB 2
`define SGATE_MSB 3
`define DET_LSB 4
`define DET_MSB 6
`define EDGE_BIT 7
`define POL_BIT 11
`define MUX_LSB 12
`define MUX_MSB 14
`define CFG_WMASK 32'h000078FF
`define CFG_RST 32'h00000000

// pull selector codes
`define PULL_NONE 2'h0
`define PULL_UP 2'h1
`define PULL_DN 2'h2
`define PULL_RPT 2'h3

// supply gate codes
`define SG_STBY 2'h0
`define SG_MAIN 2'h1
`define SG_OFF 2'h3

// event detect codes, edge bit clear
`define DET_LOW 3'h0
`define DET_HIGH 3'h1
`define DET_OFF 3'h4
// event detect codes, edge bit set
`define DET_RISE 3'h5
`define DET_FALL 3'h6
`define DET_BOTH 3'h7

// mux code of the plain gpio function
`define MUX_GPIO 3'h0

// status word bits
`define STS_LEVEL 0
`define STS_EVENT 1
`define STS_FLAG 2
`define STS_CLKREQ 3
`define STS_MAIN 4
`define STS_STBY 5
`define STS_OE 6
`define STS_WAKE 7

`endif

// File: hdl/gpio_pin_pkg.sv
// types and mode decoding shared by the pin control files
// assumes the register header is on the include path
package gpio_pin_pkg;
`include "gpio_pin_regs.svh"

    // decoded event mode
    typedef enum logic [2:0] {
        EVM_LOW,
        EVM_HIGH,
        EVM_OFF,
        EVM_RISE,
        EVM_FALL,
        EVM_BOTH,
        EVM_RSVD
    } evm_t;

    // edge bit and detect field to event mode
    function automatic evm_t decode_mode(input logic edge_en,
                                         input logic [2:0] det);
        evm_t m;
        m = EVM_RSVD;
        if (!edge_en) begin
            case (det)
                `DET_LOW: m = EVM_LOW;
                `DET_HIGH: m = EVM_HIGH;
                `DET_OFF: m = EVM_OFF;
                default: m = EVM_RSVD;
            endcase
        end else begin
            case (det)
                `DET_RISE: m = EVM_RISE;
                `DET_FALL: m = EVM_FALL;
                `DET_BOTH: m = EVM_BOTH;
                default: m = EVM_RSVD;
            endcase
        end
        return m;
    endfunction

    // true for the edge-triggered modes
    function automatic logic is_edge_mode(input evm_t m);
        return (m == EVM_RISE) || (m == EVM_FALL) || (m == EVM_BOTH);
    endfunction
endpackage

// File: hdl/gpio_pin_event_detect.sv
// pin synchroniser and event detector for one pin
// assumes pin_i is asynchronous and all else is on clk_i
module gpio_pin_event_detect
    import gpio_pin_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire logic invert_i,
    input wire logic enable_i,
    input wire evm_t mode_i,
    output logic level_o,
    output logic event_o
);
    logic sync1_r; // first stage, read by sync2_r only
    logic sync2_r; // synchronised pin level
    logic prev_r; // sensed level one cycle back
    logic sense; // level after polarity
    logic rise; // sensed rising edge
    logic fall; // sensed falling edge
    logic hit; // mode match

    // two flops ahead of any logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
            prev_r <= sense;
        end
    end

    // polarity applies to the sensed level
    assign sense = sync2_r ^ invert_i;
    assign rise = sense & ~prev_r;
    assign fall = ~sense & prev_r;

    // mode selects the matching condition
    always_comb begin
        case (mode_i)
            EVM_LOW: hit = ~sense;
            EVM_HIGH: hit = sense;
            EVM_RISE: hit = rise;
            EVM_FALL: hit = fall;
            EVM_BOTH: hit = rise | fall;
            EVM_OFF: hit = 1'b0;
            default: hit = 1'b0;
        endcase
    end

    assign level_o = sync2_r;
    assign event_o = enable_i & hit;
endmodule

// File: hdl/gpio_pin_event_pad_control.sv
// apb register slave, event selector and pad control for one pin
// assumes an apb master on CLK_SYS_I and a pad cell outside that
// resolves the pad wire from the output, enable and pull controls
//
// Added by the designer: register access over APB and the placing of the registers.
`include "gpio_pin_regs.svh"
module gpio_pin_event_pad_control
    import gpio_pin_pkg::*;
#(
    parameter bit OVP_PIN = 1'b0 // pin has over-voltage protection
)
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // selected function drive, same clock
    input wire logic FN_OUT_I,
    input wire logic FN_OE_I,
    input wire logic ANALOG_SEL_I,
    // rail power-good pins, asynchronous
    input wire logic MAIN_RAIL_GOOD_I,
    input wire logic STANDBY_RAIL_GOOD_I,
    // pad
    input wire logic PAD_I,
    output logic PAD_O,
    output logic PAD_OE_O,
    output logic PAD_IE_O,
    output logic PULL_UP_O,
    output logic PULL_DN_O,
    output logic KEEPER_O,
    // event side
    output logic EVENT_O,
    output logic WAKE_O,
    output logic CLK_REQ_O
);
    // configuration and flags
    logic [31:0] cfg_r; // pin configuration word
    logic [31:0] cfg_nxt;
    logic flag_r; // sticky event flag
    logic flag_nxt;

    // apb answer registers
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // rail synchronisers
    logic main_s1_r; // first stage only
    logic main_s2_r;
    logic stby_s1_r; // first stage only
    logic stby_s2_r;

    // registered pad and event outputs
    logic pad_out_r;
    logic pad_oe_r;
    logic pad_ie_r;
    logic pull_up_r;
    logic pull_dn_r;
    logic keeper_r;
    logic event_r;
    logic wake_r;
    logic clk_req_r;

    // config fields
    wire [1:0] pull_sel = cfg_r[`PULL_MSB:`PULL_LSB];
    wire [1:0] supply_gate_sel = cfg_r[`SGATE_MSB:`SGATE_LSB];
    wire [2:0] det_sel = cfg_r[`DET_MSB:`DET_LSB];
    wire edge_en = cfg_r[`EDGE_BIT];
    wire polarity = cfg_r[`POL_BIT];
    wire [2:0] mux_sel = cfg_r[`MUX_MSB:`MUX_LSB];

    // apb phases
    wire setup_ph = PSEL_I & ~PENABLE_I;
    wire access_ph = PSEL_I & PENABLE_I & pready_r;
    wire hit_cfg = (PADDR_I == `CFG_OFS);
    wire hit_stat = (PADDR_I == `STAT_OFS);
    wire unmapped = ~hit_cfg & ~hit_stat;
    wire wr_cfg = access_ph & PWRITE_I & hit_cfg;
    wire wr_stat = access_ph & PWRITE_I & hit_stat;

    // event mode decode
    evm_t mode;
    assign mode = decode_mode(edge_en, det_sel);
    wire edge_mode = is_edge_mode(mode);
    wire det_active = (mode != EVM_OFF) & (mode != EVM_RSVD);

    // polarity only for non-gpio functions
    wire invert = polarity & (mux_sel != `MUX_GPIO);

    // supply gating
    wire unpowered = (supply_gate_sel == `SG_OFF);
    wire well_off;
    assign well_off =
        ((supply_gate_sel == `SG_MAIN) & ~main_s2_r) |
        ((supply_gate_sel == `SG_STBY) & ~stby_s2_r) |
        unpowered;

    // detection blocked for analog and dead pads
    wire det_enable = ~ANALOG_SEL_I & ~unpowered;

    // detector outputs
    logic pin_level;
    logic det_event;

    // synchroniser and mode matcher
    gpio_pin_event_detect u_detect (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .pin_i(PAD_I),
        .invert_i(invert),
        .enable_i(det_enable),
        .mode_i(mode),
        .level_o(pin_level),
        .event_o(det_event)
    );

    // pull controls
    wire rpt_ok = ~OVP_PIN;
    wire pull_up_nxt = ~unpowered & (pull_sel == `PULL_UP);
    wire pull_dn_nxt = ~unpowered & (pull_sel == `PULL_DN);
    wire keeper_nxt =
        ~unpowered & rpt_ok & (pull_sel == `PULL_RPT);

    // function drive, inverted by polarity for non-gpio functions
    wire pad_out_nxt = FN_OUT_I ^ invert;
    wire pad_oe_nxt = FN_OE_I & ~well_off;

    // status word
    logic [31:0] stat_word;
    always_comb begin
        stat_word = 32'h00000000;
        stat_word[`STS_LEVEL] = pin_level;
        stat_word[`STS_EVENT] = event_r;
        stat_word[`STS_FLAG] = flag_r;
        stat_word[`STS_CLKREQ] = clk_req_r;
        stat_word[`STS_MAIN] = main_s2_r;
        stat_word[`STS_STBY] = stby_s2_r;
        stat_word[`STS_OE] = pad_oe_r;
        stat_word[`STS_WAKE] = edge_mode;
    end

    // read data chosen at setup
    wire [31:0] rd_mux = hit_cfg ? cfg_r :
                         hit_stat ? stat_word : 32'h00000000;

    // config write keeps reserved bits zero
    assign cfg_nxt = wr_cfg ? (PWDATA_I & `CFG_WMASK) : cfg_r;

    // sticky flag, set wins over write-one clear
    assign flag_nxt = det_event |
        (flag_r & ~(wr_stat & PWDATA_I[`STS_FLAG]));

    // configuration and flag
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            cfg_r <= `CFG_RST;
            flag_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            flag_r <= flag_nxt;
        end
    end

    // apb answer, one wait-free access cycle
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r <= rd_mux;
            pready_r <= 1'b1;
            pslverr_r <= unmapped;
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // rail power-good synchronisers
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            main_s1_r <= 1'b0;
            main_s2_r <= 1'b0;
            stby_s1_r <= 1'b0;
            stby_s2_r <= 1'b0;
        end else begin
            main_s1_r <= MAIN_RAIL_GOOD_I;
            main_s2_r <= main_s1_r;
            stby_s1_r <= STANDBY_RAIL_GOOD_I;
            stby_s2_r <= stby_s1_r;
        end
    end

    // pad controls
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            pad_out_r <= 1'b0;
            pad_oe_r <= 1'b0;
            pad_ie_r <= 1'b0;
            pull_up_r <= 1'b0;
            pull_dn_r <= 1'b0;
            keeper_r <= 1'b0;
        end else begin
            pad_out_r <= pad_out_nxt;
            pad_oe_r <= pad_oe_nxt;
            pad_ie_r <= ~unpowered;
            pull_up_r <= pull_up_nxt;
            pull_dn_r <= pull_dn_nxt;
            keeper_r <= keeper_nxt;
        end
    end

    // event, wake and clock request
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            event_r <= 1'b0;
            wake_r <= 1'b0;
            clk_req_r <= 1'b0;
        end else begin
            event_r <= det_event;
            wake_r <= det_event & edge_mode;
            clk_req_r <= det_active & det_enable;
        end
    end

    // outputs straight from flops
    assign PRDATA_O = prdata_r;
    assign PREADY_O = pready_r;
    assign PSLVERR_O = pslverr_r;
    assign PAD_O = pad_out_r;
    assign PAD_OE_O = pad_oe_r;
    assign PAD_IE_O = pad_ie_r;
    assign PULL_UP_O = pull_up_r;
    assign PULL_DN_O = pull_dn_r;
    assign KEEPER_O = keeper_r;
    assign EVENT_O = event_r;
    assign WAKE_O = wake_r;
    assign CLK_REQ_O = clk_req_r;
endmodule

// File: sim/gpio_pin_board_model.sv
// board signal at the pad of one pin
// assumes pad cell controls from the block, board drive from the bench
module gpio_pin_board_model (
    input wire logic clk_i,
    input wire logic drv_en_i,
    input wire logic drv_i,
    input wire logic pin_i,
    input wire logic pin_oe_i,
    input wire logic up_i,
    input wire logic dn_i,
    input wire logic keep_i,
    output logic level_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_r = 1'b0; // level the keeper holds
    logic alt_r = 1'b0; // floating wire pattern
    // remember the wire and run the floating pattern
    always_ff @(posedge clk_i) begin
        last_r <= level_o;
        alt_r <= ~alt_r;
    end
    // pin driver first, then board, then resistors
    always_comb begin
        if (pin_oe_i) level_o = pin_i;
        else if (drv_en_i) level_o = drv_i;
        else if (up_i) level_o = 1'b1;
        else if (dn_i) level_o = 1'b0;
        else if (keep_i) level_o = last_r;
        else level_o = alt_r;
    end
endmodule

// File: sim/gpio_pin_event_pad_control_monitor.sv
// assertions on the ports of the pin event and pad control block
// assumes apb writes are the only way to change the configuration
`include "gpio_pin_regs.svh"
module gpio_pin_event_pad_control_monitor #(
    parameter bit OVP_PIN = 1'b0
) (
    input wire logic CLK_SYS_I, RST_I, PSEL_I, PENABLE_I, PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic PREADY_O, ANALOG_SEL_I, MAIN_RAIL_GOOD_I,
    input wire logic PAD_I, PAD_OE_O, PAD_IE_O, PULL_UP_O, KEEPER_O,
    input wire logic EVENT_O, WAKE_O, CLK_REQ_O
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] cfg_r; // copy of the written configuration
    wire wr_cfg = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I
        && PADDR_I == `CFG_OFS;
    // detection neither unpowered, analog nor inverted
    wire live = cfg_r[3:2] != 2'h3 && !ANALOG_SEL_I
        && !(cfg_r[11] && cfg_r[14:12] != 3'h0);
    // follow configuration writes
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) cfg_r <= '0;
        else if (wr_cfg) cfg_r <= PWDATA_I & `CFG_WMASK;
    end
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    sequence s_setup; PSEL_I && !PENABLE_I; endsequence
    sequence s_access; PSEL_I && PENABLE_I; endsequence
    property p_ready;
        s_setup ##1 s_access |-> PREADY_O ##1 !PREADY_O;
    endproperty
    property p_wake; WAKE_O |-> cfg_r[7] || $past(cfg_r[7]); endproperty
    property p_off;
        (cfg_r[7:4] == 4'h4) [*4] |-> !EVENT_O && !WAKE_O;
    endproperty
    property p_clk_off; (cfg_r[7:4] == 4'h4) [*2] |-> !CLK_REQ_O; endproperty
    property p_clk_on;
        (live && cfg_r[7:4] == 4'h0) [*3] |-> CLK_REQ_O;
    endproperty
    property p_lvl_hi;
        (live && cfg_r[7:4] == 4'h1 && PAD_I) [*5] |-> EVENT_O;
    endproperty
    property p_lvl_lo;
        (live && cfg_r[7:4] == 4'h0 && !PAD_I) [*5] |-> EVENT_O;
    endproperty
    property p_gate_main;
        (cfg_r[3:2] == 2'h1 && !MAIN_RAIL_GOOD_I) [*4] |-> !PAD_OE_O;
    endproperty
    property p_unpowered;
        (cfg_r[3:2] == 2'h3) [*2] |-> !PAD_OE_O && !PAD_IE_O && !PULL_UP_O;
    endproperty
    property p_keeper;
        KEEPER_O |-> !OVP_PIN && $past(cfg_r[1:0]) == 2'h3;
    endproperty
    a_ready: assert property (p_ready) else $error("ready late");
    a_wake: assert property (p_wake) else $error("level wake");
    a_off: assert property (p_off) else $error("event while off");
    a_clk_off: assert property (p_clk_off) else $error("clock req");
    a_clk_on: assert property (p_clk_on) else $error("no clock req");
    a_lvl_hi: assert property (p_lvl_hi) else $error("no high");
    a_lvl_lo: assert property (p_lvl_lo) else $error("no low");
    a_gate_main: assert property (p_gate_main) else $error("oe");
    a_unpowered: assert property (p_unpowered) else $error("pad on");
    a_keeper: assert property (p_keeper) else $error("keeper");
endmodule
bind gpio_pin_event_pad_control gpio_pin_event_pad_control_monitor
    #(.OVP_PIN(OVP_PIN)) i_mon (.CLK_SYS_I, .RST_I, .PSEL_I, .PENABLE_I,
    .PWRITE_I, .PADDR_I, .PWDATA_I, .PREADY_O, .ANALOG_SEL_I,
    .MAIN_RAIL_GOOD_I, .PAD_I, .PAD_OE_O, .PAD_IE_O, .PULL_UP_O,
    .KEEPER_O, .EVENT_O, .WAKE_O, .CLK_REQ_O);

// File: sim/testbench.sv
// self-checking bench of the pin event and pad control block
// assumes the design, checker and board model are compiled first
`include "gpio_pin_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, fo = 0, foe = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, d;
    logic pready, pslverr, er, ana = 0, mg = 1, sg = 1, dv = 0, pad;
    logic de = 1; // board drives the pad
    logic po, oe, ie, pu, pdn, kp, ev, wk, cr, p;
    logic [3:0] m; // edge bit and detect field
    logic [1:0] g, pl; // supply gate and pull codes
    int bad_count = 0, n_checks = 0, cyc = 0, ne, nw;
    gpio_pin_event_pad_control i_dut (.CLK_SYS_I(clk), .RST_I(rst),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .FN_OUT_I(fo), .FN_OE_I(foe),
        .ANALOG_SEL_I(ana), .MAIN_RAIL_GOOD_I(mg),
        .STANDBY_RAIL_GOOD_I(sg), .PAD_I(pad), .PAD_O(po), .PAD_OE_O(oe),
        .PAD_IE_O(ie), .PULL_UP_O(pu), .PULL_DN_O(pdn), .KEEPER_O(kp),
        .EVENT_O(ev), .WAKE_O(wk), .CLK_REQ_O(cr));
    gpio_pin_board_model i_board (.clk_i(clk), .drv_en_i(de),
        .drv_i(dv), .pin_i(po), .pin_oe_i(oe), .up_i(pu), .dn_i(pdn),
        .keep_i(kp), .level_o(pad));
    always #10 clk = ~clk;
    // cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, s);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    // event rises and wake pulses over eight cycles
    task automatic count8();
        logic evp;
        ne = 0;
        nw = 0;
        evp = ev;
        repeat (8) begin
            @(posedge clk);
            ne += int'(ev === 1'b1 && !evp);
            nw += int'(wk === 1'b1);
            evp = ev;
        end
    endtask
    // expected level event for sensed level s
    function automatic logic exp_lvl(input logic [3:0] md, input logic s);
        return (md == 4'h0 && !s) || (md == 4'h1 && s);
    endfunction
    // expected edge pulses for a sensed change to s
    function automatic int exp_edg(input logic [3:0] md, input logic s);
        return int'(md == 4'hF || (md == 4'hD && s) || (md == 4'hE && !s));
    endfunction
    initial begin
        void'($urandom(68));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, `CFG_OFS, 32'h0);
        chk("cfg reset", `CFG_RST, rd);
        chk("reset event", 32'h1, ev);
        for (int i = 0; i < 6; i++) begin
            d = $urandom;
            apb(1'b1, `CFG_OFS, d);
            apb(1'b0, `CFG_OFS, 32'h0);
            chk("cfg", d & `CFG_WMASK, rd);
        end
        apb(1'b1, 12'h008, 32'hFFFFFFFF);
        chk("unmapped err", 32'h1, er);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped data", 32'h0, rd);
        $display("register test done");
        // every edge and detect code, sense straight then inverted
        for (int i = 0; i < 32; i++) begin
            m = i[3:0];
            p = i[4];
            dv <= p;
            apb(1'b1, `CFG_OFS, {19'h0, p, p, 3'h0, m, 4'h0});
            repeat (6) @(posedge clk);
            chk("event low", exp_lvl(m, 1'b0), ev);
            chk("clock req", m < 4'h2 || m > 4'hC, cr);
            dv <= ~p;
            count8();
            chk("rises up", exp_lvl(m, 1'b1) + exp_edg(m, 1'b1), ne);
            chk("wakes up", exp_edg(m, 1'b1), nw);
            dv <= p;
            count8();
            chk("rises dn", exp_lvl(m, 1'b0) + exp_edg(m, 1'b0), ne);
            chk("wakes dn", exp_edg(m, 1'b0), nw);
        end
        ana <= 1'b1;
        dv <= 1'b0;
        apb(1'b1, `CFG_OFS, 32'h0);
        repeat (6) @(posedge clk);
        chk("analog event", 32'h0, ev);
        chk("analog clock", 32'h0, cr);
        ana <= 1'b0;
        $display("event test done");
        // supply gate, rails and pulls with random function drive
        for (int i = 0; i < 24; i++) begin
            g = i[1:0];
            pl = 2'($urandom);
            apb(1'b1, `CFG_OFS, {24'h0, 4'h4, g, pl});
            {fo, foe, mg, sg} <= 4'($urandom);
            repeat (5) @(posedge clk);
            chk("oe", foe && !(g == 2'h0 && !sg || g == 2'h1 && !mg
                || g == 2'h3), oe);
            chk("ie", g != 2'h3, ie);
            if (g != 2'h3) chk("pad out", fo, po);
            chk("pull", g == 2'h3 ? 3'h0 : {pl == 2'h1, pl == 2'h2,
                pl == 2'h3}, {pu, pdn, kp});
        end
        $display("pad test done");
        // pin level through pull and keeper with the board let go
        foe <= 1'b0;
        for (int i = 2; i < 8; i++) begin
            pl = i[2:1];
            p = i[0];
            de <= 1'b1;
            dv <= p;
            apb(1'b1, `CFG_OFS, {24'h0, 4'h4, 2'h2, pl});
            repeat (3) @(posedge clk);
            de <= 1'b0;
            repeat (5) @(posedge clk);
            apb(1'b0, `STAT_OFS, 32'h0);
            chk("pin level", pl == 2'h1 || pl == 2'h3 && p,
                rd[`STS_LEVEL]);
        end
        // sticky flag: cleared while off, set by a level event
        apb(1'b1, `STAT_OFS, 32'h1 << `STS_FLAG);
        apb(1'b0, `STAT_OFS, 32'h0);
        chk("flag clear", 32'h0, rd[`STS_FLAG]);
        de <= 1'b1;
        dv <= 1'b0;
        apb(1'b1, `CFG_OFS, 32'h0);
        repeat (5) @(posedge clk);
        apb(1'b1, `CFG_OFS, 32'h40);
        repeat (3) @(posedge clk);
        apb(1'b0, `STAT_OFS, 32'h0);
        chk("flag set", 32'h1, rd[`STS_FLAG]);
        chk("event off", 32'h0, rd[`STS_EVENT]);
        $display("status test done");
        report_and_stop();
    end
endmodule
